// [icc_top.sv]
// Contract
// - Control bit 7 picks timer; second default
// - Mode 001 captures both edges, flags each
// - Every-edge mode ignores events-per-interrupt field
// - Every-edge mode never sets overflow
// - Capture in idle wakes/interrupts; no capture in sleep
// - Mode 111 with enable wakes, timer regardless
// - Wake also interrupts when interrupt allowed
// - Sleep: external interrupt only, count ignored
// - Idle keeps full function if timer runs and control bit 13 is clear
// - Idle with mode 111: interrupt pin only
// - Control bits 6:5 count events per interrupt
// - Per-channel flag and enable bits
// - Per-channel 16-bit capture buffer register
// - Four-word FIFO, not-empty flag, shift on read
// - Fifth capture overflows, blocks until emptied
// - Prescaler cleared when off and on reset
//
// Purpose: Four input capture channels with FIFOs behind AXI4-Lite
// Assumes: Timer values and run states come from the timer block
// Notes: Byte address is four times the register index; see package
`timescale 1ns/100ps
module icc_top (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] cap_pin,
  input wire logic [15:0] timer_a,
  input wire logic [15:0] timer_b,
  input wire logic timer_a_run,
  input wire logic timer_b_run,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic wake
);
  logic [3:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;
  logic [15:0] ctl_ff [4];
  logic [15:0] fifo_ff [4][4];
  logic [2:0] cnt_ff [4];
  logic [3:0] ps_ff [4];
  logic [1:0] epi_ff [4];
  logic [3:0] blk_ff, ovf_ff;
  logic [3:0] flag_ff, en_ff;
  logic [1:0] pwr_ff;
  logic [11:0] awa_ff, ara_ff;
  logic aw_ff, w_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic [3:0] cap_ev, irq_ev, rd_pop, ctl_wr, ch_off;
  logic wr_go, rd_go;
  logic [11:0] ctl_addr [4];
  logic [11:0] buf_addr [4];

  always_comb begin
    ctl_addr[0] = icc_pkg::CAP1_CTL;
    ctl_addr[1] = icc_pkg::CAP2_CTL;
    ctl_addr[2] = icc_pkg::CAP7_CTL;
    ctl_addr[3] = icc_pkg::CAP8_CTL;
    buf_addr[0] = icc_pkg::CAP1_BUF;
    buf_addr[1] = icc_pkg::CAP2_BUF;
    buf_addr[2] = icc_pkg::CAP7_BUF;
    buf_addr[3] = icc_pkg::CAP8_BUF;
  end

  // Pin synchroniser; level accepted when stages two and three agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      sync3_ff <= 4'h0;
      pin_ff <= 4'h0;
    end else begin
      sync1_ff <= cap_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_ff <= (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff | sync3_ff));
    end
  end

  logic [3:0] pin_now;
  assign pin_now = (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff | sync3_ff));

  // Capture event and interrupt event per channel
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logic rise;
      logic fall;
      logic [2:0] m;
      logic run;
      logic active;
      rise = pin_now[i] & ~pin_ff[i];
      fall = ~pin_now[i] & pin_ff[i];
      m = ctl_ff[i][2:0];
      run = ctl_ff[i][icc_pkg::TSEL_BIT] ? timer_a_run : timer_b_run;
      // Idle needs a running timer and stop-in-idle clear
      active = (pwr_ff == icc_pkg::PWR_RUN) ||
        ((pwr_ff == icc_pkg::PWR_IDLE) && run &&
        !ctl_ff[i][icc_pkg::SIDL_BIT]);
      cap_ev[i] = 1'b0;
      ch_off[i] = (m == icc_pkg::M_OFF);
      case (m)
        icc_pkg::M_EVERY: cap_ev[i] = active & (rise | fall);
        icc_pkg::M_FALL: cap_ev[i] = active & fall;
        icc_pkg::M_RISE: cap_ev[i] = active & rise;
        icc_pkg::M_RISE4: cap_ev[i] = active & rise &
          (ps_ff[i] == icc_pkg::PS4_LAST);
        icc_pkg::M_RISE16: cap_ev[i] = active & rise &
          (ps_ff[i] == icc_pkg::PS16_LAST);
        default: cap_ev[i] = 1'b0;
      endcase
      if (m == icc_pkg::M_IRQONLY) begin
        // Pin is only an interrupt source; works in any power state
        irq_ev[i] = rise;
      end else if (m == icc_pkg::M_EVERY) begin
        irq_ev[i] = cap_ev[i];
      end else begin
        irq_ev[i] = cap_ev[i] &&
          (epi_ff[i] == ctl_ff[i][icc_pkg::EPI_LO +: 2]);
      end
    end
  end

  // Prescaler counts rising edges, cleared when off
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) ps_ff[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ch_off[i] || ctl_wr[i]) begin
          ps_ff[i] <= 4'h0;
        end else if (pin_now[i] & ~pin_ff[i]) begin
          if (ctl_ff[i][2:0] == icc_pkg::M_RISE4 &&
              ps_ff[i] == icc_pkg::PS4_LAST) begin
            ps_ff[i] <= 4'h0;
          end else begin
            ps_ff[i] <= ps_ff[i] + 4'h1;
          end
        end
      end
    end
  end

  // Events-per-interrupt counter
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) epi_ff[i] <= 2'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ch_off[i] || ctl_wr[i]) begin
          epi_ff[i] <= 2'h0;
        end else if (cap_ev[i]) begin
          if (irq_ev[i]) epi_ff[i] <= 2'h0;
          else epi_ff[i] <= epi_ff[i] + 2'h1;
        end
      end
    end
  end

  // FIFO: writes at count, pops shift down
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        cnt_ff[i] <= 3'h0;
        for (int j = 0; j < 4; j++) fifo_ff[i][j] <= 16'h0000;
      end
      blk_ff <= 4'h0;
      ovf_ff <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        logic [15:0] tv;
        logic [2:0] c;
        tv = ctl_ff[i][icc_pkg::TSEL_BIT] ? timer_a : timer_b;
        c = cnt_ff[i];
        if (rd_pop[i] && c != 3'h0) begin
          for (int j = 0; j < 3; j++) fifo_ff[i][j] <= fifo_ff[i][j+1];
          c = c - 3'h1;
        end
        if (cnt_ff[i] == 3'h0 || (rd_pop[i] && cnt_ff[i] == 3'h1))
          blk_ff[i] <= 1'b0;
        if (cap_ev[i]) begin
          if (cnt_ff[i] == 3'(icc_pkg::FIFO_DEPTH) || blk_ff[i]) begin
            if (ctl_ff[i][2:0] != icc_pkg::M_EVERY) begin
              ovf_ff[i] <= 1'b1;
              blk_ff[i] <= 1'b1;
            end
          end else begin
            fifo_ff[i][c[1:0]] <= tv;
            c = c + 3'h1;
          end
        end else if (ctl_wr[i] && !wd_ff[icc_pkg::OVF_BIT]) begin
          ovf_ff[i] <= 1'b0;
        end
        cnt_ff[i] <= c;
      end
    end
  end

  // AXI4-Lite write channel
  assign wr_go = aw_ff & w_ff & ~s_axi_bvalid;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 12'h000;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= icc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awa_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wd_ff <= s_axi_wdata;
        ws_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= icc_pkg::RESP_OKAY;
        if (awa_ff > icc_pkg::PWR_STATE &&
            awa_ff[1:0] == 2'h0 || awa_ff < icc_pkg::CAP1_BUF)
          s_axi_bresp <= icc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_ff;
  assign s_axi_wready = ~w_ff;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ctl_wr[i] = wr_go && awa_ff == ctl_addr[i] && ws_ff[0];
    end
  end

  // Control, enable and power registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) ctl_ff[i] <= icc_pkg::CTL_RST;
      en_ff <= 4'h0;
      pwr_ff <= icc_pkg::PWR_RUN;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ctl_wr[i]) begin
          ctl_ff[i] <= (wd_ff[15:0] & icc_pkg::CTL_WMASK) |
            (ctl_ff[i] & ~icc_pkg::CTL_WMASK);
        end
      end
      if (wr_go && awa_ff == icc_pkg::IRQ_EN && ws_ff[0])
        en_ff <= wd_ff[3:0];
      if (wr_go && awa_ff == icc_pkg::PWR_STATE && ws_ff[0])
        pwr_ff <= wd_ff[1:0];
    end
  end

  // Sticky flags, write one to clear; a new event wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_ff <= 4'h0;
    end else begin
      logic [3:0] clr;
      clr = (wr_go && awa_ff == icc_pkg::IRQ_FLAG && ws_ff[0]) ?
        wd_ff[3:0] : 4'h0;
      flag_ff <= (flag_ff & ~clr) | irq_ev;
    end
  end

  // Interrupt and wake outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq <= |((flag_ff | irq_ev) & en_ff);
      wake <= (pwr_ff != icc_pkg::PWR_RUN) && |(irq_ev & en_ff);
    end
  end

  // AXI4-Lite read channel; buffer read pops the FIFO
  always_comb begin
    rd_go = s_axi_arvalid & s_axi_arready;
    for (int i = 0; i < 4; i++) rd_pop[i] = rd_go && s_axi_araddr == buf_addr[i];
  end
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= icc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= icc_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == icc_pkg::IRQ_FLAG) begin
        s_axi_rdata <= {28'h0, flag_ff};
      end else if (s_axi_araddr == icc_pkg::IRQ_EN) begin
        s_axi_rdata <= {28'h0, en_ff};
      end else if (s_axi_araddr == icc_pkg::PWR_STATE) begin
        s_axi_rdata <= {30'h0, pwr_ff};
      end else begin
        s_axi_rresp <= icc_pkg::RESP_SLVERR;
        for (int i = 0; i < 4; i++) begin
          if (s_axi_araddr == buf_addr[i]) begin
            s_axi_rdata <= {16'h0, fifo_ff[i][0]};
            s_axi_rresp <= icc_pkg::RESP_OKAY;
          end else if (s_axi_araddr == ctl_addr[i]) begin
            s_axi_rdata <= {16'h0, ctl_ff[i][15:5], ovf_ff[i],
              cnt_ff[i] != 3'h0, ctl_ff[i][2:0]};
            s_axi_rresp <= icc_pkg::RESP_OKAY;
          end
        end
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [icc_pkg.sv]
// Purpose: Constants shared by the input capture block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Register words hold 16-bit values in bits 15:0
package icc_pkg;
  localparam int NCH = 4;
  localparam int AW = 12;
  // Register indices; the byte address is four times the index
  localparam logic [AW-1:0] CAP1_BUF_IDX = 12'h140;
  localparam logic [AW-1:0] CAP1_CTL_IDX = 12'h142;
  localparam logic [AW-1:0] CAP2_BUF_IDX = 12'h144;
  localparam logic [AW-1:0] CAP2_CTL_IDX = 12'h146;
  localparam logic [AW-1:0] CAP7_BUF_IDX = 12'h158;
  localparam logic [AW-1:0] CAP7_CTL_IDX = 12'h15A;
  localparam logic [AW-1:0] CAP8_BUF_IDX = 12'h15C;
  localparam logic [AW-1:0] CAP8_CTL_IDX = 12'h15E;
  // Flag, enable and power-state registers follow the same scheme
  localparam logic [AW-1:0] IRQ_FLAG_IDX = 12'h160;
  localparam logic [AW-1:0] IRQ_EN_IDX = 12'h161;
  localparam logic [AW-1:0] PWR_STATE_IDX = 12'h162;
  localparam logic [AW-1:0] CAP1_BUF = CAP1_BUF_IDX << 2;
  localparam logic [AW-1:0] CAP1_CTL = CAP1_CTL_IDX << 2;
  localparam logic [AW-1:0] CAP2_BUF = CAP2_BUF_IDX << 2;
  localparam logic [AW-1:0] CAP2_CTL = CAP2_CTL_IDX << 2;
  localparam logic [AW-1:0] CAP7_BUF = CAP7_BUF_IDX << 2;
  localparam logic [AW-1:0] CAP7_CTL = CAP7_CTL_IDX << 2;
  localparam logic [AW-1:0] CAP8_BUF = CAP8_BUF_IDX << 2;
  localparam logic [AW-1:0] CAP8_CTL = CAP8_CTL_IDX << 2;
  localparam logic [AW-1:0] IRQ_FLAG = IRQ_FLAG_IDX << 2;
  localparam logic [AW-1:0] IRQ_EN = IRQ_EN_IDX << 2;
  localparam logic [AW-1:0] PWR_STATE = PWR_STATE_IDX << 2;
  localparam int TSEL_BIT = 7;
  localparam int EPI_LO = 5;
  localparam int OVF_BIT = 4;
  localparam int BNE_BIT = 3;
  localparam int SIDL_BIT = 13;
  localparam logic [15:0] CTL_WMASK = 16'h20E7;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [2:0] M_OFF = 3'h0;
  localparam logic [2:0] M_EVERY = 3'h1;
  localparam logic [2:0] M_FALL = 3'h2;
  localparam logic [2:0] M_RISE = 3'h3;
  localparam logic [2:0] M_RISE4 = 3'h4;
  localparam logic [2:0] M_RISE16 = 3'h5;
  localparam logic [2:0] M_IRQONLY = 3'h7;
  localparam logic [3:0] PS4_LAST = 4'h3;
  localparam logic [3:0] PS16_LAST = 4'hF;
  localparam int FIFO_DEPTH = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] PWR_RUN = 2'h0;
  localparam logic [1:0] PWR_IDLE = 2'h1;
  localparam logic [1:0] PWR_SLEEP = 2'h2;
endpackage

// [icc_props.sv]
// Purpose: Port-level checks for the input capture block
// Assumes: Bound to the top module, one clock domain
// Notes: Bus checks cover the register paths of every channel
`timescale 1ns/100ps
module icc_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic wake
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read answer dropped");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while answering");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write answer late");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write answer dropped");
  property p_rd_width;
    s_axi_rvalid && s_axi_rresp == icc_pkg::RESP_OKAY
      |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("upper read bits set");
  property p_wake_pulse;
    wake |=> !wake;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake longer than one cycle");
  property p_wake_irq;
    wake |-> irq;
  endproperty
  a_wake_irq: assert property (p_wake_irq)
    else $error("wake without interrupt");
endmodule

// [icc_edge_src.sv]
// Purpose: Edge source standing in for sensors on the capture pins
// Assumes: Pins idle low and are always driven
// Notes: Each level is held past the input synchroniser
`timescale 1ns/100ps
module icc_edge_src (
  input wire logic clock,
  output logic [3:0] cap_pin
);
  initial cap_pin = 4'h0;
  task automatic level(input int ch, input logic v);
    @(posedge clock);
    cap_pin[ch] <= v;
    repeat (8) @(posedge clock);
  endtask
endmodule

// [testbench.sv]
// Purpose: Register-level tests of the input capture block
// Assumes: Timers are held still around each edge
// Notes: Channels 0..3 sit at the four register pairs
`timescale 1ns/100ps
module testbench;
  logic clock, arst_n, timer_a_run, timer_b_run;
  logic [15:0] timer_a, timer_b;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb, cap_pin;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq, wake;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  int mismatches = 0, total_checks = 0, cycles = 0, wakes = 0;
  localparam logic [11:0] CT[4] = '{icc_pkg::CAP1_CTL, icc_pkg::CAP2_CTL,
    icc_pkg::CAP7_CTL, icc_pkg::CAP8_CTL};
  localparam logic [11:0] BF[4] = '{icc_pkg::CAP1_BUF, icc_pkg::CAP2_BUF,
    icc_pkg::CAP7_BUF, icc_pkg::CAP8_BUF};
  icc_top u_dut (.clock, .arst_n, .cap_pin, .timer_a, .timer_b,
    .timer_a_run, .timer_b_run, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .wake);
  icc_edge_src u_src (.clock, .cap_pin);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (wake === 1'b1) wakes++;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask
  task automatic pulse(input int ch);
    u_src.level(ch, 1'b1);
    u_src.level(ch, 1'b0);
  endtask
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {timer_a, timer_b} = {16'h1111, 16'h2222};
    {timer_a_run, timer_b_run} = 2'h3;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    for (int c = 0; c < 4; c++) rdc(CT[c], 32'h0);
    rd(12'h100);
    chk({30'h0, rd_resp}, {30'h0, icc_pkg::RESP_SLVERR});
    wr(CT[0], 32'h0083);
    wr(CT[1], 32'h0003);
    pulse(0);
    pulse(1);
    rdc(BF[0], 32'h1111);
    rdc(BF[1], 32'h2222);
    rdc(CT[0], 32'h0083);
    wr(CT[2], 32'h0003);
    for (int k = 1; k <= 5; k++) begin
      timer_b <= 16'(k);
      pulse(2);
    end
    rdc(CT[2], 32'h001B);
    for (int k = 1; k <= 4; k++) rdc(BF[2], 32'(k));
    rdc(CT[2], 32'h0013);
    wr(icc_pkg::IRQ_FLAG, 32'hF);
    wr(CT[3], 32'h0061);
    for (int k = 0; k < 6; k++) begin
      u_src.level(3, !k[0]);
      rdc(icc_pkg::IRQ_FLAG, 32'h8);
      wr(icc_pkg::IRQ_FLAG, 32'h8);
    end
    rdc(CT[3], 32'h0069);
    u_src.level(3, 1'b1);
    chk({31'h0, irq}, 32'h0);
    wr(icc_pkg::IRQ_EN, 32'h8);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(icc_pkg::IRQ_FLAG, 32'h8);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    wr(icc_pkg::IRQ_EN, 32'h0);
    for (int n = 0; n < 4; n++) begin
      wr(CT[0], 32'(n << 5) | 32'h3);
      wr(icc_pkg::IRQ_FLAG, 32'hF);
      repeat (n) pulse(0);
      rdc(icc_pkg::IRQ_FLAG, 32'h0);
      pulse(0);
      rdc(icc_pkg::IRQ_FLAG, 32'h1);
      repeat (n + 1) rd(BF[0]);
    end
    wr(CT[1], 32'h0004);
    repeat (3) pulse(1);
    wr(CT[1], 32'h0000);
    wr(CT[1], 32'h0004);
    repeat (3) pulse(1);
    rdc(CT[1], 32'h0004);
    pulse(1);
    rdc(CT[1], 32'h000C);
    rd(BF[1]);
    wr(CT[0], 32'h0007);
    wr(CT[1], 32'h0003);
    wr(icc_pkg::IRQ_FLAG, 32'hF);
    wr(icc_pkg::IRQ_EN, 32'h1);
    {timer_a_run, timer_b_run} <= 2'h0;
    wr(icc_pkg::PWR_STATE, 32'h2);
    pulse(0);
    pulse(1);
    chk(32'(wakes), 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(icc_pkg::IRQ_FLAG, 32'h1);
    rdc(CT[0], 32'h0007);
    rdc(CT[1], 32'h0003);
    timer_b_run <= 1'b1;
    wr(icc_pkg::PWR_STATE, 32'h1);
    pulse(1);
    rdc(CT[1], 32'h000B);
    pulse(0);
    rdc(CT[0], 32'h0007);
    chk(32'(wakes), 32'h2);
    rd(BF[1]);
    wr(CT[1], 32'h2003);
    pulse(1);
    rdc(CT[1], 32'h2003);
    tally_and_finish();
  end
endmodule
bind icc_top icc_props u_props (.clock, .arst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .wake);
